// >>> logic/lig_pkg.sv
// Constants for the line input gain control register bank.
// What this block does
// R1: Left and right gains are separate, 32 steps of 1.5dB each, plus mute.
// R2: Step zero gives -40.5dB, the top step gives +6dB.
// R3: After reset both channels are muted.
// R4: While the input stage is disabled, volume and mute sit at defaults.
// R5: Volume or mute writes made while disabled are dropped.
// R6: Both line inputs share one gain stage and one set of controls.
// R7: Inputs work as two mono single-ended or one stereo single-ended.
// R8: Host enables the input stage before writing the channel registers.
// R9: Right register holds right gain, mute and line two select.
// R10: Left register holds left gain and mute for the shared stage.
// R11: Gain is a step index, one step per increment; mute separate.
`default_nettype none
package lig_pkg;
    // Register offsets on the 2-wire serial control interface
    localparam logic [7:0] LIG_OFS_RIGHT = 8'h0a;
    localparam logic [7:0] LIG_OFS_LEFT = 8'h0b;
    localparam logic [7:0] LIG_OFS_DRV_EN = 8'h14;
    localparam logic [7:0] LIG_OFS_MIX_EN = 8'h16;

    // Channel register fields
    localparam int LIG_GAIN_W = 5;
    localparam int LIG_GAIN_LSB = 0;
    localparam int LIG_LINE2_BIT = 5;
    localparam int LIG_MUTE_BIT = 6;
    localparam logic [7:0] LIG_RIGHT_MASK = 8'h7f;
    localparam logic [7:0] LIG_LEFT_MASK = 8'h5f;

    // Enable register fields
    localparam int LIG_DRV_LINE_EN_BIT = 0;
    localparam int LIG_MIX_LINE1_BIT = 0;
    localparam int LIG_MIX_LINE2_BIT = 1;
    localparam int LIG_MIX_STEREO_BIT = 2;

    // Reset values
    localparam logic [4:0] LIG_GAIN_DEFAULT = 5'h1b;
    localparam logic [7:0] LIG_CHAN_RESET = 8'h5b;
    localparam logic [7:0] LIG_DRV_RESET = 8'h00;
    localparam logic [7:0] LIG_MIX_RESET = 8'h00;

    // Gain in half-dB units: step * 3 - 81
    localparam logic [7:0] LIG_HALF_DB_PER_STEP = 8'h03;
    localparam logic [7:0] LIG_HALF_DB_FLOOR = 8'h51;

    // Neutral bus address, arbitrary value
    localparam logic [6:0] LIG_DEV_ADDR = 7'h2a;

    typedef enum logic [8:0] {
        LIG_ST_IDLE = 9'h001,
        LIG_ST_ADDR = 9'h002,
        LIG_ST_AACK = 9'h004,
        LIG_ST_REG = 9'h008,
        LIG_ST_RACK = 9'h010,
        LIG_ST_WR = 9'h020,
        LIG_ST_WACK = 9'h040,
        LIG_ST_RD = 9'h080,
        LIG_ST_MACK = 9'h100
    } lig_state_type;
endpackage : lig_pkg
`default_nettype wire

// >>> logic/lig_channel.sv
// One channel of the shared line input gain stage.
`timescale 1ns/1ps
`default_nettype none
module lig_channel (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic [4:0] i_step,
    input wire logic i_mute,
    input wire logic i_enable,
    output logic [4:0] o_step,
    output logic o_muted,
    output logic [7:0] o_gain_half_db
);
    logic [4:0] step_q;
    logic [4:0] step_d;
    logic muted_q;
    logic muted_d;
    logic [7:0] gain_q;
    logic [7:0] gain_d;

    always_comb begin
        step_d = i_step; // R11
        muted_d = i_mute | ~i_enable; // R3
        // Step zero is -40.5dB, step 31 is +6dB
        gain_d = 8'({3'h0, i_step} * lig_pkg::LIG_HALF_DB_PER_STEP)
            - lig_pkg::LIG_HALF_DB_FLOOR; // R2
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            step_q <= lig_pkg::LIG_GAIN_DEFAULT;
            muted_q <= 1'b1; // R3
            gain_q <= 8'h00;
        end else begin
            step_q <= step_d;
            muted_q <= muted_d;
            gain_q <= gain_d;
        end
    end

    assign o_step = step_q;
    assign o_muted = muted_q;
    assign o_gain_half_db = gain_q;
endmodule : lig_channel
`default_nettype wire

// >>> logic/lig_top.sv
// Line input gain control registers behind the 2-wire serial interface.
`timescale 1ns/1ps
`default_nettype none
module lig_top #(
    parameter logic [6:0] DEV_ADDR = lig_pkg::LIG_DEV_ADDR
) (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic o_line_enable,
    output logic o_line2_select,
    output logic o_stereo_mode,
    output logic o_line1_mix_en,
    output logic o_line2_mix_en,
    output logic [4:0] o_gain_right,
    output logic [4:0] o_gain_left,
    output logic o_mute_right,
    output logic o_mute_left,
    output logic [7:0] o_gain_half_db_right,
    output logic [7:0] o_gain_half_db_left
);
    // Serial line history for edge detection
    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    // Serial engine state
    lig_pkg::lig_state_type state_q;
    lig_pkg::lig_state_type state_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic rw_q;
    logic rw_d;
    logic sda_oe_q;
    logic sda_oe_d;
    logic sda_out_q;
    logic wr_en;
    logic [7:0] rdata;
    logic [7:0] rdata_next;

    // Register bank state
    logic [7:0] right_q;
    logic [7:0] right_d;
    logic [7:0] left_q;
    logic [7:0] left_d;
    logic [7:0] drv_q;
    logic [7:0] drv_d;
    logic [7:0] mix_q;
    logic [7:0] mix_d;
    logic line2_q;
    logic stereo_q;
    logic l1mix_q;
    logic l2mix_q;
    logic line_en_q;
    logic stage_on;

    function automatic logic [7:0] read_reg(input logic [7:0] a,
            input logic [7:0] r, input logic [7:0] l,
            input logic [7:0] d, input logic [7:0] m);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            lig_pkg::LIG_OFS_RIGHT: v = r; // R9
            lig_pkg::LIG_OFS_LEFT: v = l; // R10
            lig_pkg::LIG_OFS_DRV_EN: v = d;
            lig_pkg::LIG_OFS_MIX_EN: v = m;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_reg

    assign scl_rise = i_scl & ~scl_q;
    assign scl_fall = ~i_scl & scl_q;
    assign start_seen = scl_q & i_scl & sda_q & ~i_sda;
    assign stop_seen = scl_q & i_scl & ~sda_q & i_sda;
    assign rdata = read_reg(ptr_q, right_q, left_q, drv_q, mix_q);
    assign rdata_next = read_reg(ptr_q + 8'h01, right_q, left_q, drv_q,
        mix_q);
    assign stage_on = drv_q[lig_pkg::LIG_DRV_LINE_EN_BIT];

    // Serial engine next state
    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        cnt_d = cnt_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        sda_oe_d = sda_oe_q;
        wr_en = 1'b0;
        if (start_seen) begin
            state_d = lig_pkg::LIG_ST_ADDR;
            cnt_d = 4'h0;
            sda_oe_d = 1'b0;
        end else if (stop_seen) begin
            state_d = lig_pkg::LIG_ST_IDLE;
            sda_oe_d = 1'b0;
        end else begin
            unique case (state_q)
                lig_pkg::LIG_ST_IDLE: begin
                    sda_oe_d = 1'b0;
                end
                lig_pkg::LIG_ST_ADDR, lig_pkg::LIG_ST_REG,
                lig_pkg::LIG_ST_WR: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], i_sda};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == 4'h8) begin
                        cnt_d = 4'h0;
                        sda_oe_d = 1'b1;
                        if (state_q == lig_pkg::LIG_ST_ADDR) begin
                            if (shift_q[7:1] == DEV_ADDR) begin
                                rw_d = shift_q[0];
                                state_d = lig_pkg::LIG_ST_AACK;
                            end else begin
                                sda_oe_d = 1'b0;
                                state_d = lig_pkg::LIG_ST_IDLE;
                            end
                        end else if (state_q == lig_pkg::LIG_ST_REG) begin
                            ptr_d = shift_q;
                            state_d = lig_pkg::LIG_ST_RACK;
                        end else begin
                            wr_en = 1'b1;
                            state_d = lig_pkg::LIG_ST_WACK;
                        end
                    end
                end
                lig_pkg::LIG_ST_AACK: begin
                    if (scl_fall) begin
                        if (rw_q) begin
                            sda_oe_d = ~rdata[7];
                            shift_d = {rdata[6:0], 1'b0};
                            cnt_d = 4'h1;
                            state_d = lig_pkg::LIG_ST_RD;
                        end else begin
                            sda_oe_d = 1'b0;
                            state_d = lig_pkg::LIG_ST_REG;
                        end
                    end
                end
                lig_pkg::LIG_ST_RACK: begin
                    if (scl_fall) begin
                        sda_oe_d = 1'b0;
                        state_d = lig_pkg::LIG_ST_WR;
                    end
                end
                lig_pkg::LIG_ST_WACK: begin
                    if (scl_fall) begin
                        sda_oe_d = 1'b0;
                        ptr_d = ptr_q + 8'h01;
                        state_d = lig_pkg::LIG_ST_WR;
                    end
                end
                lig_pkg::LIG_ST_RD: begin
                    if (scl_fall) begin
                        if (cnt_q == 4'h8) begin
                            sda_oe_d = 1'b0;
                            cnt_d = 4'h0;
                            state_d = lig_pkg::LIG_ST_MACK;
                        end else begin
                            sda_oe_d = ~shift_q[7];
                            shift_d = {shift_q[6:0], 1'b0};
                            cnt_d = cnt_q + 4'h1;
                        end
                    end
                end
                lig_pkg::LIG_ST_MACK: begin
                    // Host not acknowledging ends the read
                    if (scl_rise && i_sda) begin
                        state_d = lig_pkg::LIG_ST_IDLE;
                    end else if (scl_fall) begin
                        ptr_d = ptr_q + 8'h01;
                        sda_oe_d = ~rdata_next[7];
                        shift_d = {rdata_next[6:0], 1'b0};
                        cnt_d = 4'h1;
                        state_d = lig_pkg::LIG_ST_RD;
                    end
                end
                default: begin
                    state_d = lig_pkg::LIG_ST_IDLE;
                    sda_oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            state_q <= lig_pkg::LIG_ST_IDLE;
            shift_q <= 8'h00;
            cnt_q <= 4'h0;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            sda_oe_q <= 1'b0;
            sda_out_q <= 1'b0;
        end else begin
            scl_q <= i_scl;
            sda_q <= i_sda;
            state_q <= state_d;
            shift_q <= shift_d;
            cnt_q <= cnt_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            sda_oe_q <= sda_oe_d;
            // Open drain only ever pulls low
            sda_out_q <= 1'b0;
        end
    end

    // Register bank next state
    always_comb begin
        right_d = right_q;
        left_d = left_q;
        drv_d = drv_q;
        mix_d = mix_q;
        if (wr_en && ptr_q == lig_pkg::LIG_OFS_DRV_EN) begin
            drv_d = shift_q; // R8
        end
        if (wr_en && ptr_q == lig_pkg::LIG_OFS_MIX_EN) begin
            mix_d = shift_q; // R7
        end
        if (!stage_on) begin
            // Disabled stage holds defaults and drops channel register writes
            right_d = lig_pkg::LIG_CHAN_RESET & lig_pkg::LIG_RIGHT_MASK; // R4
            left_d = lig_pkg::LIG_CHAN_RESET & lig_pkg::LIG_LEFT_MASK; // R4
        end else if (wr_en && ptr_q == lig_pkg::LIG_OFS_RIGHT) begin
            right_d = shift_q & lig_pkg::LIG_RIGHT_MASK; // R5
        end else if (wr_en && ptr_q == lig_pkg::LIG_OFS_LEFT) begin
            left_d = shift_q & lig_pkg::LIG_LEFT_MASK; // R5
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            right_q <= lig_pkg::LIG_CHAN_RESET & lig_pkg::LIG_RIGHT_MASK;
            left_q <= lig_pkg::LIG_CHAN_RESET & lig_pkg::LIG_LEFT_MASK;
            drv_q <= lig_pkg::LIG_DRV_RESET;
            mix_q <= lig_pkg::LIG_MIX_RESET;
            line2_q <= 1'b0;
            stereo_q <= 1'b0;
            l1mix_q <= 1'b0;
            l2mix_q <= 1'b0;
            line_en_q <= 1'b0;
        end else begin
            right_q <= right_d;
            left_q <= left_d;
            drv_q <= drv_d;
            mix_q <= mix_d;
            line2_q <= right_d[lig_pkg::LIG_LINE2_BIT]; // R6
            stereo_q <= mix_d[lig_pkg::LIG_MIX_STEREO_BIT]; // R7
            l1mix_q <= mix_d[lig_pkg::LIG_MIX_LINE1_BIT];
            l2mix_q <= mix_d[lig_pkg::LIG_MIX_LINE2_BIT];
            line_en_q <= drv_d[lig_pkg::LIG_DRV_LINE_EN_BIT];
        end
    end

    // Shared stage, one channel each side
    logic [1:0][4:0] ch_step_in;
    logic [1:0] ch_mute_in;
    logic [1:0][4:0] ch_step;
    logic [1:0] ch_muted;
    logic [1:0][7:0] ch_gain;

    assign ch_step_in[0] = right_q[lig_pkg::LIG_GAIN_LSB +: 5];
    assign ch_step_in[1] = left_q[lig_pkg::LIG_GAIN_LSB +: 5];
    assign ch_mute_in[0] = right_q[lig_pkg::LIG_MUTE_BIT];
    assign ch_mute_in[1] = left_q[lig_pkg::LIG_MUTE_BIT];

    for (genvar g = 0; g < 2; g++) begin : g_chan
        lig_channel u_chan ( // R1
            .i_sys_clk(i_sys_clk),
            .i_srst(i_srst),
            .i_step(ch_step_in[g]),
            .i_mute(ch_mute_in[g]),
            .i_enable(stage_on),
            .o_step(ch_step[g]),
            .o_muted(ch_muted[g]),
            .o_gain_half_db(ch_gain[g])
        );
    end

    assign o_sda_out = sda_out_q;
    assign o_sda_oe = sda_oe_q;
    assign o_line_enable = line_en_q;
    assign o_line2_select = line2_q;
    assign o_stereo_mode = stereo_q;
    assign o_line1_mix_en = l1mix_q;
    assign o_line2_mix_en = l2mix_q;
    assign o_gain_right = ch_step[0];
    assign o_gain_left = ch_step[1];
    assign o_mute_right = ch_muted[0];
    assign o_mute_left = ch_muted[1];
    assign o_gain_half_db_right = ch_gain[0];
    assign o_gain_half_db_left = ch_gain[1];
endmodule : lig_top
`default_nettype wire

// >>> verification/lig_host_model.sv
// Host model on the 2-wire serial control interface.
`timescale 1ns/1ps
`default_nettype none
module lig_host_model (
    input wire logic i_sys_clk,
    input wire logic i_sda_oe,
    output logic o_scl,
    output logic o_sda
);
    localparam int QTR = 8;
    logic scl_q = 1'b1;
    logic low_q = 1'b0;
    assign o_scl = scl_q;
    // Pull-up: released wire reads high
    assign o_sda = ~(low_q | i_sda_oe);
    task automatic step(input logic scl, input logic low);
        repeat (QTR) @(posedge i_sys_clk);
        scl_q <= scl;
        low_q <= low;
    endtask : step
    task automatic bit_xfer(input logic low, output logic seen);
        step(1'b0, low);
        step(1'b1, low);
        repeat (QTR / 2) @(posedge i_sys_clk);
        seen = o_sda;
        step(1'b0, low);
    endtask : bit_xfer
    task automatic start_cond();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask : start_cond
    task automatic stop_cond();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask : stop_cond
    task automatic xfer_byte(input logic [7:0] tx, input logic ack_low,
                             output logic [7:0] rx, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(~tx[i], s);
            rx[i] = s;
        end
        bit_xfer(ack_low, s);
        ack = ~s;
    endtask : xfer_byte
    task automatic write_reg(input logic [6:0] adr, input logic [7:0] ofs,
                             input logic [7:0] data, output logic ack);
        logic [7:0] rx;
        logic a0;
        logic a1;
        logic a2;
        start_cond();
        xfer_byte({adr, 1'b0}, 1'b0, rx, a0);
        xfer_byte(ofs, 1'b0, rx, a1);
        xfer_byte(data, 1'b0, rx, a2);
        stop_cond();
        ack = a0 & a1 & a2;
    endtask : write_reg
    task automatic read_reg(input logic [6:0] adr, input logic [7:0] ofs,
                            output logic [7:0] data);
        logic [7:0] rx;
        logic a;
        start_cond();
        xfer_byte({adr, 1'b0}, 1'b0, rx, a);
        xfer_byte(ofs, 1'b0, rx, a);
        start_cond();
        xfer_byte({adr, 1'b1}, 1'b0, rx, a);
        // Host NACK ends the read
        xfer_byte(8'hff, 1'b0, data, a);
        stop_cond();
    endtask : read_reg
    task automatic read_pair(input logic [6:0] adr, input logic [7:0] ofs,
                             output logic [7:0] d0, output logic [7:0] d1);
        logic [7:0] rx;
        logic a;
        start_cond();
        xfer_byte({adr, 1'b0}, 1'b0, rx, a);
        xfer_byte(ofs, 1'b0, rx, a);
        start_cond();
        xfer_byte({adr, 1'b1}, 1'b0, rx, a);
        // Host ACK asks for the next register
        xfer_byte(8'hff, 1'b1, d0, a);
        xfer_byte(8'hff, 1'b0, d1, a);
        stop_cond();
    endtask : read_pair
endmodule : lig_host_model
`default_nettype wire

// >>> verification/lig_top_assertions.sv
// Concurrent checks on the line input gain control ports.
`timescale 1ns/1ps
`default_nettype none
module lig_top_assertions (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_scl,
    input wire logic o_line_enable,
    input wire logic o_line2_select,
    input wire logic o_stereo_mode,
    input wire logic [4:0] o_gain_right,
    input wire logic [4:0] o_gain_left,
    input wire logic o_mute_right,
    input wire logic o_mute_left,
    input wire logic [7:0] o_gain_half_db_right,
    input wire logic [7:0] o_gain_half_db_left
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    property p_mute_off;
        !o_line_enable [*3] |-> o_mute_right && o_mute_left;
    endproperty
    a_mute_off: assert property (p_mute_off)
        else $error("mute not forced while stage off");
    property p_gain_off;
        !o_line_enable [*3] |-> o_gain_right == 5'h1b
            && o_gain_left == 5'h1b;
    endproperty
    a_gain_off: assert property (p_gain_off)
        else $error("gain not at default while stage off");
    property p_half_r;
        $stable(o_gain_right) [*3] |->
            o_gain_half_db_right == {3'h0, o_gain_right} * 8'h03 - 8'h51;
    endproperty
    a_half_r: assert property (p_half_r)
        else $error("right half dB value wrong");
    property p_half_l;
        $stable(o_gain_left) [*3] |->
            o_gain_half_db_left == {3'h0, o_gain_left} * 8'h03 - 8'h51;
    endproperty
    a_half_l: assert property (p_half_l)
        else $error("left half dB value wrong");
    property p_gain_chg;
        $changed(o_gain_left) |-> $past(o_line_enable)
            || $past(o_line_enable, 2) || $past(o_line_enable, 3);
    endproperty
    a_gain_chg: assert property (p_gain_chg)
        else $error("left gain moved while stage off");
    property p_unmute;
        $fell(o_mute_right) |-> $past(o_line_enable);
    endproperty
    a_unmute: assert property (p_unmute)
        else $error("right unmuted while stage off");
    property p_stereo;
        $changed(o_stereo_mode) |-> !i_scl;
    endproperty
    a_stereo: assert property (p_stereo)
        else $error("mode changed outside a commit");
    property p_line2;
        $changed(o_line2_select) |-> !i_scl;
    endproperty
    a_line2: assert property (p_line2)
        else $error("line two select changed outside a commit");
endmodule : lig_top_assertions
bind lig_top lig_top_assertions u_lig_chk (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_scl(i_scl),
    .o_line_enable(o_line_enable), .o_line2_select(o_line2_select),
    .o_stereo_mode(o_stereo_mode), .o_gain_right(o_gain_right),
    .o_gain_left(o_gain_left), .o_mute_right(o_mute_right),
    .o_mute_left(o_mute_left), .o_gain_half_db_right(o_gain_half_db_right),
    .o_gain_half_db_left(o_gain_half_db_left)
);
`default_nettype wire

// >>> verification/test_line_input_gain_control.sv
// Register level tests of the line input gain control block.
`timescale 1ns/1ps
`default_nettype none
module test_line_input_gain_control;
    localparam logic [6:0] DEV = lig_pkg::LIG_DEV_ADDR;
    logic i_sys_clk = 1'b0;
    logic i_srst = 1'b1;
    logic scl, sda, sda_out, sda_oe, line_en, line2, stereo, mix1, mix2;
    logic mute_r, mute_l, ack;
    logic [4:0] gain_r, gain_l;
    logic [7:0] half_r, half_l;
    logic [7:0] pair_0, pair_1;
    int err_total = 0;
    int n_compared = 0;
    always #2 i_sys_clk = ~i_sys_clk;
    lig_top dut (
        .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_scl(scl), .i_sda(sda),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_line_enable(line_en),
        .o_line2_select(line2), .o_stereo_mode(stereo),
        .o_line1_mix_en(mix1), .o_line2_mix_en(mix2),
        .o_gain_right(gain_r), .o_gain_left(gain_l),
        .o_mute_right(mute_r), .o_mute_left(mute_l),
        .o_gain_half_db_right(half_r), .o_gain_half_db_left(half_l)
    );
    lig_host_model u_host (
        .i_sys_clk(i_sys_clk), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda)
    );
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] ofs, input logic [7:0] data);
        u_host.write_reg(DEV, ofs, data, ack);
        check("ack", {7'h00, ack}, 8'h01);
        repeat (8) @(posedge i_sys_clk);
    endtask : wr
    task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
        logic [7:0] d;
        u_host.read_reg(DEV, ofs, d);
        check($sformatf("reg %h", ofs), d, exp);
    endtask : rd
    task automatic chk_out(input logic [7:0] r, input logic [7:0] l);
        check("right", {1'b0, mute_r, line2, gain_r}, r);
        check("left", {1'b0, mute_l, 1'b0, gain_l}, l);
    endtask : chk_out
    initial begin
        repeat (8) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        chk_out(8'h5b, 8'h5b);
        check("half", half_r, 8'h00);
        check("sda_out", {7'h00, sda_out}, 8'h00);
        rd(8'h0a, 8'h5b);
        rd(8'h0b, 8'h5b);
        rd(8'h14, 8'h00);
        rd(8'h16, 8'h00);
        wr(8'h0a, 8'h1f);
        rd(8'h0a, 8'h5b);
        chk_out(8'h5b, 8'h5b);
        wr(8'h14, 8'h01);
        check("enable", {7'h00, line_en}, 8'h01);
        wr(8'h0a, 8'h3f);
        wr(8'h0b, 8'hff);
        rd(8'h0a, 8'h3f);
        rd(8'h0b, 8'h5f);
        chk_out(8'h3f, 8'h5f);
        check("half_r", half_r, 8'h0c);
        wr(8'h0b, 8'h00);
        chk_out(8'h3f, 8'h00);
        check("half_l", half_l, 8'haf);
        u_host.read_pair(DEV, 8'h0a, pair_0, pair_1);
        check("pair 0a", pair_0, 8'h3f);
        check("pair 0b", pair_1, 8'h00);
        wr(8'h16, 8'h07);
        check("mix", {5'h00, stereo, mix2, mix1}, 8'h07);
        wr(8'h16, 8'h02);
        check("mix", {5'h00, stereo, mix2, mix1}, 8'h02);
        wr(8'h30, 8'haa);
        rd(8'h30, 8'h00);
        u_host.write_reg(7'h2b, 8'h0a, 8'h1f, ack);
        check("nak", {7'h00, ack}, 8'h00);
        chk_out(8'h3f, 8'h00);
        wr(8'h14, 8'h00);
        chk_out(8'h5b, 8'h5b);
        rd(8'h0a, 8'h5b);
        finish_test();
    end
    initial begin
        #240000;
        err_total++;
        finish_test();
    end
endmodule : test_line_input_gain_control
`default_nettype wire
